// ---- verilog/line_state_pkg.sv ----
// cache line state types, read opcodes and response fields for the
// coherent read state update block; used by the tracker and its helper
package line_state_pkg;

    // line states; binary codes fixed so a checker can read them raw
    typedef enum logic [2:0] {
        LS_INVALID = 3'h0,
        LS_UNIQUE_CLEAN = 3'h1,
        LS_UNIQUE_DIRTY = 3'h2,
        LS_SHARED_CLEAN = 3'h3,
        LS_SHARED_DIRTY = 3'h4
    } line_state_t;

    // shareable read kinds handled here
    typedef enum logic [1:0] {
        RD_NOT_SHARED_DIRTY = 2'h0,
        RD_SHARED = 2'h1,
        RD_UNIQUE = 2'h2
    } read_kind_t;

    // bit positions of the pair inside the 4-bit read response
    localparam int RESP_SHARED_BIT = 3;
    localparam int RESP_DIRTY_BIT = 2;

    // reset value of the tracked line
    localparam logic [2:0] LINE_RESET = 3'h0;

    // read request as seen when issued
    typedef struct packed {
        read_kind_t kind;
        logic [31:0] addr;
    } read_req_t;

    // response pair from the interconnect
    typedef struct packed {
        logic is_shared;
        logic pass_dirty;
    } read_resp_t;

    // policy: which legal alternative to take instead of the expected one
    typedef struct packed {
        logic snoop_filter;
        logic demote_shared;
        logic drop_clean;
    } policy_t;

endpackage : line_state_pkg

// ---- verilog/line_next_state.sv ----
// pure transition table for one line: start state, read kind, response
// pair and policy in; end state and error flag out
// assumes the caller has already applied any snoop to the start state
`timescale 1ns/1ps
module line_next_state (
    input wire line_state_pkg::line_state_t start,
    input wire line_state_pkg::read_kind_t kind,
    input wire line_state_pkg::read_resp_t resp,
    input wire line_state_pkg::policy_t policy,
    output line_state_pkg::line_state_t end_state,
    output logic illegal
);

    line_state_pkg::line_state_t expected;

    ////////////////////////////////////////////////////////////////////////
    // expected end state
    always_comb begin
        expected = start;
        illegal = 1'b0;
        // pair disallowed for the request kind
        if (kind == line_state_pkg::RD_NOT_SHARED_DIRTY && resp.is_shared && resp.pass_dirty) begin
            illegal = 1'b1;
        end
        if (kind == line_state_pkg::RD_UNIQUE && resp.is_shared) begin
            illegal = 1'b1;
        end
        unique case (start)
            line_state_pkg::LS_INVALID, line_state_pkg::LS_SHARED_CLEAN: begin
                // dirty data passed lands dirty, never clean [R2] [R3] [R5] [R7] [R8] [R11] [R12]
                unique case ({resp.is_shared, resp.pass_dirty})
                    2'h0: expected = line_state_pkg::LS_UNIQUE_CLEAN;
                    2'h1: expected = line_state_pkg::LS_UNIQUE_DIRTY;
                    2'h2: expected = line_state_pkg::LS_SHARED_CLEAN;
                    2'h3: expected = line_state_pkg::LS_SHARED_DIRTY;
                endcase
            end
            line_state_pkg::LS_UNIQUE_CLEAN, line_state_pkg::LS_UNIQUE_DIRTY: begin
                // unique lines only accept 00 and stay put [R3] [R8] [R12]
                if (resp.is_shared || resp.pass_dirty) begin
                    illegal = 1'b1;
                end
            end
            line_state_pkg::LS_SHARED_DIRTY: begin
                // dirty ownership kept; unique grant upgrades [R3] [R8] [R12]
                if (resp.pass_dirty || (resp.is_shared && kind == line_state_pkg::RD_UNIQUE)) begin
                    illegal = 1'b1;
                end
                expected = resp.is_shared ? line_state_pkg::LS_SHARED_DIRTY
                                          : line_state_pkg::LS_UNIQUE_DIRTY;
            end
            default: begin
                illegal = 1'b1;
                expected = line_state_pkg::LS_INVALID;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // legal alternative; dirty states are never dropped
    always_comb begin
        end_state = expected;
        if (policy.drop_clean && !policy.snoop_filter &&
            (expected == line_state_pkg::LS_UNIQUE_CLEAN ||
             expected == line_state_pkg::LS_SHARED_CLEAN)) begin
            end_state = line_state_pkg::LS_INVALID; // [R4]
        end else if (policy.demote_shared) begin
            if (expected == line_state_pkg::LS_UNIQUE_CLEAN) begin
                end_state = line_state_pkg::LS_SHARED_CLEAN; // [R4]
            end else if (expected == line_state_pkg::LS_UNIQUE_DIRTY) begin
                end_state = line_state_pkg::LS_SHARED_DIRTY; // [R4]
            end
        end
    end

endmodule : line_next_state

// ---- verilog/coherent_read_line_state_update.sv ----
// tracks the state of one cache line across shareable reads: issue,
// optional snoop while outstanding, response, and later local store
// assumes one outstanding read; all inputs come from logic on clk
//
// What this block does or expects of the interconnect
// (R1) interconnect never returns shared plus dirty for not-shared-dirty reads.
// (R2) not-shared-dirty from invalid: 00 UC, 01 UD, 10 SC.
// (R3) not-shared-dirty from valid lines follows the table of transitions.
// (R4) may take shared counterpart, or invalid for clean without filter.
// (R5) shared clean line receiving pass dirty ends dirty.
// (R6) interconnect may return all four pairs for shared reads.
// (R7) shared read from invalid: 00 UC, 01 UD, 10 SC, 11 SD.
// (R8) shared read from valid lines follows the table of transitions.
// (R9) interconnect keeps is shared low for unique reads.
// (R10) interconnect reports clean or dirty with pass dirty for unique reads.
// (R11) unique read from invalid: 00 UC, 01 UD.
// (R12) unique read from valid lines follows the table of transitions.
// (R13) later store to a unique line is applied separately.
// (R14) snoop arriving while read outstanding is applied first.
// (R15) pass dirty response records write-back responsibility.
`timescale 1ns/1ps
module coherent_read_line_state_update (
    input wire clk,
    input wire rst_n,
    input wire read_issue,
    input wire line_state_pkg::read_req_t read_req,
    input wire resp_valid,
    input wire [3:0] rresp,
    input wire snoop_valid,
    input wire [31:0] snoop_addr,
    input wire line_state_pkg::line_state_t snoop_state,
    input wire store_valid,
    input wire line_state_pkg::policy_t policy,
    output logic busy,
    output line_state_pkg::line_state_t line_state,
    output logic [31:0] line_addr,
    output logic writeback_owed,
    output logic resp_error,
    output logic done
);

    typedef struct packed {
        logic busy;
        line_state_pkg::read_kind_t kind;
        line_state_pkg::line_state_t line;
        logic [31:0] addr;
        logic owed;
        logic err;
        logic done;
    } state_t;

    state_t cur;
    state_t next_cur;
    line_state_pkg::read_resp_t resp;
    line_state_pkg::line_state_t start;
    line_state_pkg::line_state_t computed;
    logic illegal;

    ////////////////////////////////////////////////////////////////////////
    // response pair taken from its bit positions
    assign resp = '{is_shared: rresp[line_state_pkg::RESP_SHARED_BIT],
                    pass_dirty: rresp[line_state_pkg::RESP_DIRTY_BIT]};

    // a snoop landing with the response is folded in before the table
    assign start = (snoop_valid && snoop_addr == cur.addr) ? snoop_state : cur.line; // [R14]

    line_next_state u_table (
        .start(start),
        .kind(cur.kind),
        .resp(resp),
        .policy(policy),
        .end_state(computed),
        .illegal(illegal)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        if (snoop_valid && snoop_addr == cur.addr) begin
            next_cur.line = snoop_state; // [R14]
            // snoop that strips dirty also takes the write-back duty away
            if (snoop_state != line_state_pkg::LS_UNIQUE_DIRTY &&
                snoop_state != line_state_pkg::LS_SHARED_DIRTY) begin
                next_cur.owed = 1'b0;
            end
        end
        if (cur.busy && resp_valid) begin
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
            next_cur.err = illegal; // [R1] [R9]
            // illegal response leaves the line as it stood
            if (!illegal) begin
                next_cur.line = computed;
                if (resp.pass_dirty) begin
                    next_cur.owed = 1'b1; // [R15]
                end
                if (computed == line_state_pkg::LS_INVALID) begin
                    next_cur.owed = 1'b0;
                end
            end
        end else if (!cur.busy && read_issue) begin
            next_cur.busy = 1'b1;
            next_cur.kind = read_req.kind;
            next_cur.err = 1'b0;
            // new address means a fresh line; old one assumed evicted
            if (read_req.addr != cur.addr) begin
                next_cur.addr = read_req.addr;
                next_cur.line = line_state_pkg::LS_INVALID;
                next_cur.owed = 1'b0;
            end
        end else if (!cur.busy && store_valid) begin
            // store only after completion, as its own step [R13]
            if (cur.line == line_state_pkg::LS_UNIQUE_CLEAN ||
                cur.line == line_state_pkg::LS_UNIQUE_DIRTY) begin
                next_cur.line = line_state_pkg::LS_UNIQUE_DIRTY; // [R13]
                next_cur.owed = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.line <= line_state_pkg::line_state_t'(line_state_pkg::LINE_RESET);
        end else begin
            cur <= next_cur;
        end
    end

    assign busy = cur.busy;
    assign line_state = cur.line;
    assign line_addr = cur.addr;
    assign writeback_owed = cur.owed;
    assign resp_error = cur.err;
    assign done = cur.done;

endmodule : coherent_read_line_state_update

// ---- tb/line_state_checker.sv ----
// assertions on the line state tracker ports
// assumes binding onto coherent_read_line_state_update, one clock
`timescale 1ns/1ps
module line_state_checker (
    input wire clk,
    input wire rst_n,
    input wire read_issue,
    input wire resp_valid,
    input wire [3:0] rresp,
    input wire snoop_valid,
    input wire [31:0] snoop_addr,
    input wire line_state_pkg::line_state_t snoop_state,
    input wire store_valid,
    input wire line_state_pkg::policy_t policy,
    input wire busy,
    input wire line_state_pkg::line_state_t line_state,
    input wire [31:0] line_addr,
    input wire writeback_owed,
    input wire resp_error,
    input wire done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // response taken with no coincident snoop; start state is line_state
    wire rt = resp_valid && busy && !snoop_valid;
    wire rp = rt && policy == 3'h0;
    AST_DONE: assert property (resp_valid && busy |=> done && !busy)
        else $error("no done after response");
    AST_I_00: assert property (rp && line_state == 3'h0 && rresp[3:2] == 2'h0
        |=> line_state == 3'h1)
        else $error("invalid plus 00 not unique clean");
    AST_I_01: assert property (rp && line_state == 3'h0 && rresp[3:2] == 2'h1
        |=> line_state == 3'h2)
        else $error("invalid plus 01 not unique dirty");
    AST_I_10: assert property (rp && line_state == 3'h0 && rresp[3:2] == 2'h2
        |=> resp_error || line_state == 3'h3)
        else $error("invalid plus 10 not shared clean");
    AST_SD_00: assert property (rp && line_state == 3'h4 && rresp[3:2] == 2'h0
        |=> line_state == 3'h2)
        else $error("shared dirty plus 00 not unique dirty");
    AST_PD: assert property (rt && rresp[2] |=> resp_error ||
        (writeback_owed && (line_state == 3'h2 || line_state == 3'h4)))
        else $error("pass dirty left line clean");
    AST_FILTER: assert property (rt && policy.snoop_filter && line_state != 3'h0
        |=> line_state != 3'h0)
        else $error("line dropped with snoop filter");
    AST_STORE: assert property (store_valid && !busy && !read_issue
        && (line_state == 3'h1 || line_state == 3'h2) |=> line_state == 3'h2 && writeback_owed)
        else $error("store not applied");
    AST_SNOOP: assert property (snoop_valid && busy && !resp_valid
        && snoop_addr == line_addr |=> line_state == $past(snoop_state))
        else $error("snoop not applied");
    C_PD: cover property (rt && rresp[2]);
    C_ST: cover property (store_valid && !busy);
    C_SN: cover property (snoop_valid && busy);
endmodule : line_state_checker
bind coherent_read_line_state_update line_state_checker chk_u (.clk, .rst_n, .read_issue,
    .resp_valid, .rresp, .snoop_valid, .snoop_addr, .snoop_state, .store_valid, .policy,
    .busy, .line_state, .line_addr, .writeback_owed, .resp_error, .done);

// ---- tb/ic_model.sv ----
// interconnect model: one response pulse per outstanding read
// assumes busy from the tracker; bad lets a raw pair through
`timescale 1ns/1ps
module ic_model (
    input wire clk,
    input wire busy,
    input wire line_state_pkg::read_kind_t kind,
    input wire [1:0] pick,
    input wire bad,
    input wire [3:0] dly,
    output logic resp_valid = 1'b0,
    output logic [3:0] rresp = 4'h0
);
    logic [3:0] cnt = 4'h0;
    // wait dly cycles while busy; idle rresp toggles so stale values never pass
    always @(negedge clk) begin
        if (busy && !resp_valid && cnt == dly) begin
            resp_valid <= 1'b1;
            rresp[3] <= pick[1] && (bad || kind != line_state_pkg::RD_UNIQUE);
            rresp[2] <= pick[0] && (bad || !(pick[1] && kind == 2'h0));
        end else begin
            resp_valid <= 1'b0;
            rresp <= ~rresp;
            cnt <= busy ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule : ic_model

// ---- tb/tb_coherent_read_line_state_update.sv ----
// bench: every start, kind and pair once, then random reads and stores
// assumes the interconnect model answers each read; 10 MHz clock
`timescale 1ns/1ps
module tb_coherent_read_line_state_update;
    logic clk = 1'b0, rst_n = 1'b0, read_issue = 1'b0, snoop_valid = 1'b0;
    logic store_valid = 1'b0, bad = 1'b0, busy, owed, rerr, done, rv;
    line_state_pkg::read_req_t req = '0;
    line_state_pkg::line_state_t ls;
    line_state_pkg::policy_t pol = '0;
    logic [31:0] la, seed = 32'hc2d9, cyc = 32'h0;
    logic [3:0] rresp, dly = 4'h0;
    logic [2:0] ss = 3'h0;
    logic [1:0] pick = 2'h0;
    int n_errors = 0, checked = 0;
    coherent_read_line_state_update dut_u (.clk, .rst_n, .read_issue, .read_req(req),
        .resp_valid(rv), .rresp, .snoop_valid, .snoop_addr(req.addr),
        .snoop_state(line_state_pkg::line_state_t'(ss)), .store_valid, .policy(pol),
        .busy, .line_state(ls), .line_addr(la), .writeback_owed(owed), .resp_error(rerr), .done);
    ic_model ic_u (.clk, .busy, .kind(req.kind), .pick, .bad, .dly, .resp_valid(rv), .rresp);
    ////////////////////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    // xorshift, fixed seed so a failing run repeats
    function logic [31:0] nx();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : nx
    // end state: illegal pairs keep the start; drop wins over demote
    function automatic logic [2:0] ex(input logic [2:0] s, input logic [1:0] k,
        input logic [1:0] p, input logic [2:0] pl, output logic err);
        logic [2:0] e;
        err = (k == 2'h0 && p == 2'h3) || (k == 2'h2 && p[1]) || (s == 3'h4 && p[0])
            || ((s == 3'h1 || s == 3'h2) && p != 2'h0);
        e = (s == 3'h1 || s == 3'h2) ? s : (s == 3'h4) ? (p[1] ? 3'h4 : 3'h2) : {1'b0, p} + 3'h1;
        if (!pl[2] && pl[0] && (e == 3'h1 || e == 3'h3)) e = 3'h0;
        else if (pl[1] && (e == 3'h1 || e == 3'h2)) e = e + 3'h2;
        return err ? s : e;
    endfunction : ex
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task final_report();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // hang guard, well above the at most ~6900 cycles the run can need
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'h4e20) begin
            n_errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] s, e, ms;
        logic [1:0] p;
        logic err, snp;
        ms = 3'h0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        chk(ls, 3'h0);
        chk(busy, 1'b0);
        for (int i = 0; i < 360; i++) begin
            // mid-run reset between reads; line and duty must come back clear
            if (i == 200) begin
                rst_n = 1'b0;
                @(negedge clk);
                rst_n = 1'b1;
                chk(ls, 3'h0);
                chk(owed, 1'b0);
                ms = 3'h0;
            end
            snp = i < 60 || nx() % 2;
            req = {(i < 60) ? 2'((i / 4) % 3) : 2'(nx() % 3), (i < 60) ? 32'h40 : nx() & 32'hc0};
            s = (req.addr != la) ? 3'h0 : ms;
            ss = (i < 60) ? 3'(i / 12) : 3'(nx() % 5);
            if (snp) s = ss;
            pol = (i < 60) ? 3'h0 : 3'(nx());
            bad = i < 60 || nx() % 16 == 0;
            dly = 4'(nx());
            pick = (i < 60) ? 2'(i) : 2'(nx());
            if (!bad && (s == 3'h1 || s == 3'h2)) pick = 2'h0;
            if (!bad && s == 3'h4) pick[0] = 1'b0;
            p = 2'h0;
            read_issue = 1'b1;
            @(negedge clk);
            read_issue = 1'b0;
            snoop_valid = snp;
            @(negedge clk);
            snoop_valid = 1'b0;
            for (int w = 0; w < 40; w++) begin
                if (rv === 1'b1) p = rresp[3:2];
                if (done === 1'b1) break;
                @(negedge clk);
            end
            chk(done, 1'b1);
            e = ex(s, req.kind, p, pol, err);
            chk(ls, e);
            chk(rerr, err);
            chk(la, req.addr);
            if (!err && p[0]) chk(owed, 1'b1);
            if (!err && e == 3'h0) chk(owed, 1'b0);
            ms = e;
            if ((e == 3'h1 || e == 3'h2) && nx() % 2) begin
                @(negedge clk);
                store_valid = 1'b1;
                @(negedge clk);
                store_valid = 1'b0;
                chk(ls, 3'h2);
                chk(owed, 1'b1);
                ms = 3'h2;
            end
        end
        final_report();
    end
endmodule : tb_coherent_read_line_state_update
